// File: logic/clk_ctrl_cfg.svh
`ifndef CLK_CTRL_CFG_SVH
`define CLK_CTRL_CFG_SVH
// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define CC_ADDR_PIN_MODE 32'h4002_0400
`define CC_ADDR_RUN_STOP 32'h4002_0401
`define CC_ADDR_CLK_SEL 32'h4002_0404
`define CC_ADDR_PLL_CTRL 32'h4002_0C02
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CC_RST_PIN_MODE 8'h00
`define CC_RST_RUN_STOP 8'hC0
`define CC_RST_CLK_SEL 8'h00
`define CC_RST_PLL_CTRL 8'h00
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CC_PM_MAIN_EXT 7
`define CC_PM_MAIN_OSC 6
`define CC_PM_SUB_EXT 5
`define CC_PM_SUB_OSC 4
`define CC_PM_DRIVE_HI 2
`define CC_PM_DRIVE_LO 1
`define CC_PM_GAIN 0
`define CC_RS_MAIN_STOP 7
`define CC_RS_SUB_STOP 6
`define CC_RS_RC_STOP 0
`define CC_CS_CPU_STAT 7
`define CC_CS_CPU_CHOICE 6
`define CC_CS_MAIN_STAT 5
`define CC_CS_MAIN_CHOICE 4
`define CC_PLL_SRC 7
`define CC_PLL_DIV_HI 3
`define CC_PLL_DIV_LO 2
`define CC_PLL_MULT 1
`define CC_PLL_RUN 0
// ----------------------------------------------------------------
// Divider shift codes (divide by 1, 2, 4)
// ----------------------------------------------------------------
`define CC_DIV_SHIFT_1 2'h0
`define CC_DIV_SHIFT_2 2'h1
`define CC_DIV_SHIFT_4 2'h2
`endif

// File: logic/clk_ctrl_pkg.sv
package clk_ctrl_pkg;
    // ----------------------------------------------------------------
    // Oscillator pin modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {PIN_PORT, PIN_XTAL, PIN_EXT} pin_mode_t;

    // Decode an external-select / oscillator-select pair
    function automatic pin_mode_t decode_pin_mode(input logic ext_sel, input logic osc_sel);
        if (!osc_sel)
        begin
            return PIN_PORT;
        end
        else if (ext_sel)
        begin
            return PIN_EXT;
        end
        else
        begin
            return PIN_XTAL;
        end
    endfunction : decode_pin_mode
endpackage : clk_ctrl_pkg

// File: logic/clk_source_ctrl.sv
`timescale 1ns/1ps
`include "clk_ctrl_cfg.svh"
// How it works
// - Pin mode register takes one write after reset, readable, resets to zero
// - Main pin bits: 01 crystal, 11 external clock, else port mode
// - Sub pin bits: 01 32 kHz crystal, 11 external sub clock, else port
// - Sub drive bits: 00 low power, 01 normal, 10 ultra low; 11 banned
// - Sub pin and drive bits clear only on power-on reset
// - CPU choice 0 main, 1 sub; read-only status shows source in use
// - Main choice 0 fast RC, 1 fast system clock; status shows actual
// - Status bits 7 and 5 ignore writes, hardware updates them
// - Peripheral clock follows CPU source; software stops peripherals first
// - Main stop bit: 0 runs crystal or external input, resets to 1
// - Sub stop bit: 0 runs sub crystal or external input, resets to 1
// - Fast RC stop bit: 0 runs, 1 stops, resets to 0
// - The oscillator feeding the CPU clock is never stopped, except by a stop write on the edge the CPU leaves the sub clock or the main clock switches
// - PLL register fields at 7, 3:2, 1, 0; bits 6:4 read zero
// - PLL source 0 fast RC, 1 fast system clock; run bit enables
// - Multiplier 0 x12, 1 x16; divider 00 /1, 01 /2, 1x /4
module clk_source_ctrl (
    input wire logic clk,                 // System clock, 100 MHz
    input wire logic rst_n,               // Sync reset, active low
    input wire logic por_n,               // Sync power-on reset, active low
    input wire logic [31:0] bus_addr,     // Byte address
    input wire logic [7:0] bus_wdata,     // Write data
    input wire logic bus_wr,              // Write strobe
    input wire logic bus_rd,              // Read strobe
    input wire logic main_settled,        // Main oscillator settle done
    input wire logic sub_settled,         // Sub oscillator usable
    output logic [7:0] bus_rdata_q,       // Read data, one cycle later
    output clk_ctrl_pkg::pin_mode_t main_mode_q, // Main pin mode
    output clk_ctrl_pkg::pin_mode_t sub_mode_q,  // Sub pin mode
    output logic main_osc_en_q,           // Main crystal / input enabled
    output logic sub_osc_en_q,            // Sub crystal / input enabled
    output logic fast_rc_en_q,            // Fast RC running
    output logic [1:0] sub_drive_q,       // Sub drive level
    output logic main_gain_q,             // Main high gain
    output logic cpu_on_sub_q,            // CPU and peripherals on sub clock
    output logic main_on_fast_q,          // Main clock from fast system clock
    output logic pll_run_q,               // PLL on
    output logic pll_src_fast_q,          // PLL fed from fast system clock
    output logic pll_mult16_q,            // PLL x16 when high, else x12
    output logic [1:0] pll_div_shift_q    // PLL divide as shift count
);
    import clk_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic main_ext_clock_sel_q, main_osc_pin_sel_q, main_gain_sel_q;
    logic sub_ext_clock_sel_q, sub_osc_pin_sel_q, sub_drive_hi_q, sub_drive_lo_q;
    logic pin_mode_written_q;
    logic main_osc_stop_q, sub_osc_stop_q, fast_rc_stop_q;
    logic cpu_clock_choice_q, main_clock_choice_q;
    logic pll_source_sel_q, pll_div_hi_q, pll_div_lo_q, pll_mult_sel_q, pll_run_sel_q;
    logic cpu_clock_status, main_clock_status;
    logic may_stop_main, may_stop_sub, may_stop_rc, stop_ok_main, stop_ok_sub, stop_ok_rc;
    logic sys_rst, wr_pin, wr_run, wr_sel, wr_pll;
    logic fast_ok, sub_ok;
    pin_mode_t main_mode, sub_mode;
    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // Power-on reset also resets everything else
    assign sys_rst = !rst_n || !por_n;
    assign wr_pin = bus_wr && (bus_addr == `CC_ADDR_PIN_MODE);
    assign wr_run = bus_wr && (bus_addr == `CC_ADDR_RUN_STOP);
    assign wr_sel = bus_wr && (bus_addr == `CC_ADDR_CLK_SEL);
    assign wr_pll = bus_wr && (bus_addr == `CC_ADDR_PLL_CTRL);

    // Pin modes, source readiness, and stop permission (a source named by the choice bits counts as in use)
    assign main_mode = decode_pin_mode(main_ext_clock_sel_q, main_osc_pin_sel_q);
    assign sub_mode = decode_pin_mode(sub_ext_clock_sel_q, sub_osc_pin_sel_q);
    assign fast_ok = (main_mode != PIN_PORT) && !main_osc_stop_q && main_settled;
    assign sub_ok = (sub_mode != PIN_PORT) && !sub_osc_stop_q && sub_settled;
    assign stop_ok_main = may_stop_main && !(!cpu_clock_choice_q && main_clock_choice_q);
    assign stop_ok_sub = may_stop_sub && !cpu_clock_choice_q;
    assign stop_ok_rc = may_stop_rc && !(!cpu_clock_choice_q && !main_clock_choice_q);
    // ----------------------------------------------------------------
    // Pin mode register
    // ----------------------------------------------------------------
    // Main fields: one write per reset, later writes dropped
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            main_ext_clock_sel_q <= 1'(`CC_RST_PIN_MODE >> `CC_PM_MAIN_EXT);
            main_osc_pin_sel_q <= 1'(`CC_RST_PIN_MODE >> `CC_PM_MAIN_OSC);
            main_gain_sel_q <= 1'(`CC_RST_PIN_MODE >> `CC_PM_GAIN);
            pin_mode_written_q <= 1'b0;
        end
        else if (wr_pin && !pin_mode_written_q)
        begin
            main_ext_clock_sel_q <= bus_wdata[`CC_PM_MAIN_EXT];
            main_osc_pin_sel_q <= bus_wdata[`CC_PM_MAIN_OSC];
            main_gain_sel_q <= bus_wdata[`CC_PM_GAIN];
            pin_mode_written_q <= 1'b1;
        end
    end

    // Sub fields: cleared only by power-on reset
    always_ff @(posedge clk)
    begin
        if (!por_n)
        begin
            sub_ext_clock_sel_q <= 1'(`CC_RST_PIN_MODE >> `CC_PM_SUB_EXT);
            sub_osc_pin_sel_q <= 1'(`CC_RST_PIN_MODE >> `CC_PM_SUB_OSC);
            sub_drive_hi_q <= 1'(`CC_RST_PIN_MODE >> `CC_PM_DRIVE_HI);
            sub_drive_lo_q <= 1'(`CC_RST_PIN_MODE >> `CC_PM_DRIVE_LO);
        end
        else if (rst_n && wr_pin && !pin_mode_written_q)
        begin
            sub_ext_clock_sel_q <= bus_wdata[`CC_PM_SUB_EXT];
            sub_osc_pin_sel_q <= bus_wdata[`CC_PM_SUB_OSC];
            sub_drive_hi_q <= bus_wdata[`CC_PM_DRIVE_HI];
            sub_drive_lo_q <= bus_wdata[`CC_PM_DRIVE_LO];
        end
    end
    // ----------------------------------------------------------------
    // Run/stop register
    // ----------------------------------------------------------------
    // A stop request for the source in use is refused
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            main_osc_stop_q <= 1'(`CC_RST_RUN_STOP >> `CC_RS_MAIN_STOP);
            sub_osc_stop_q <= 1'(`CC_RST_RUN_STOP >> `CC_RS_SUB_STOP);
            fast_rc_stop_q <= 1'(`CC_RST_RUN_STOP >> `CC_RS_RC_STOP);
        end
        else if (wr_run)
        begin
            if (!bus_wdata[`CC_RS_MAIN_STOP] || stop_ok_main)
            begin
                main_osc_stop_q <= bus_wdata[`CC_RS_MAIN_STOP];
            end
            if (!bus_wdata[`CC_RS_SUB_STOP] || stop_ok_sub)
            begin
                sub_osc_stop_q <= bus_wdata[`CC_RS_SUB_STOP];
            end
            if (!bus_wdata[`CC_RS_RC_STOP] || stop_ok_rc)
            begin
                fast_rc_stop_q <= bus_wdata[`CC_RS_RC_STOP];
            end
        end
    end
    // ----------------------------------------------------------------
    // Clock select and PLL registers
    // ----------------------------------------------------------------
    // Only choice bits are writable; status bits come from hardware
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cpu_clock_choice_q <= 1'(`CC_RST_CLK_SEL >> `CC_CS_CPU_CHOICE);
            main_clock_choice_q <= 1'(`CC_RST_CLK_SEL >> `CC_CS_MAIN_CHOICE);
        end
        else if (wr_sel)
        begin
            cpu_clock_choice_q <= bus_wdata[`CC_CS_CPU_CHOICE];
            main_clock_choice_q <= bus_wdata[`CC_CS_MAIN_CHOICE];
        end
    end

    // PLL fields
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pll_source_sel_q <= 1'(`CC_RST_PLL_CTRL >> `CC_PLL_SRC);
            pll_div_hi_q <= 1'(`CC_RST_PLL_CTRL >> `CC_PLL_DIV_HI);
            pll_div_lo_q <= 1'(`CC_RST_PLL_CTRL >> `CC_PLL_DIV_LO);
            pll_mult_sel_q <= 1'(`CC_RST_PLL_CTRL >> `CC_PLL_MULT);
            pll_run_sel_q <= 1'(`CC_RST_PLL_CTRL >> `CC_PLL_RUN);
        end
        else if (wr_pll)
        begin
            pll_source_sel_q <= bus_wdata[`CC_PLL_SRC];
            pll_div_hi_q <= bus_wdata[`CC_PLL_DIV_HI];
            pll_div_lo_q <= bus_wdata[`CC_PLL_DIV_LO];
            pll_mult_sel_q <= bus_wdata[`CC_PLL_MULT];
            pll_run_sel_q <= bus_wdata[`CC_PLL_RUN];
        end
    end
    // ----------------------------------------------------------------
    // Source switching and stop guard
    // ----------------------------------------------------------------
    clk_switch_status u_switch (
        .clk(clk),
        .rst_n(!sys_rst),
        .cpu_choice(cpu_clock_choice_q),
        .main_choice(main_clock_choice_q),
        .fast_ok(fast_ok),
        .rc_ok(!fast_rc_stop_q),
        .sub_ok(sub_ok),
        .cpu_status_q(cpu_clock_status),
        .main_status_q(main_clock_status)
    );

    osc_stop_guard u_guard (
        .cpu_status(cpu_clock_status),
        .main_status(main_clock_status),
        .may_stop_main(may_stop_main),
        .may_stop_sub(may_stop_sub),
        .may_stop_rc(may_stop_rc)
    );
    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Registered copies of the clock controls
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            main_mode_q <= PIN_PORT;
            sub_mode_q <= PIN_PORT;
            main_osc_en_q <= 1'b0;
            sub_osc_en_q <= 1'b0;
            fast_rc_en_q <= 1'b1;
            sub_drive_q <= 2'h0;
            main_gain_q <= 1'b0;
            cpu_on_sub_q <= 1'b0;
            main_on_fast_q <= 1'b0;
        end
        else
        begin
            main_mode_q <= main_mode;
            sub_mode_q <= sub_mode;
            main_osc_en_q <= (main_mode != PIN_PORT) && !main_osc_stop_q;
            sub_osc_en_q <= (sub_mode != PIN_PORT) && !sub_osc_stop_q;
            fast_rc_en_q <= !fast_rc_stop_q;
            sub_drive_q <= {sub_drive_hi_q, sub_drive_lo_q};
            main_gain_q <= main_gain_sel_q;
            cpu_on_sub_q <= cpu_clock_status;
            main_on_fast_q <= main_clock_status;
        end
    end

    // PLL controls
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pll_run_q <= 1'b0;
            pll_src_fast_q <= 1'b0;
            pll_mult16_q <= 1'b0;
            pll_div_shift_q <= `CC_DIV_SHIFT_1;
        end
        else
        begin
            pll_run_q <= pll_run_sel_q;
            pll_src_fast_q <= pll_source_sel_q;
            pll_mult16_q <= pll_mult_sel_q;
            if (pll_div_hi_q)
            begin
                pll_div_shift_q <= `CC_DIV_SHIFT_4;
            end
            else if (pll_div_lo_q)
            begin
                pll_div_shift_q <= `CC_DIV_SHIFT_2;
            end
            else
            begin
                pll_div_shift_q <= `CC_DIV_SHIFT_1;
            end
        end
    end

    // Read port; unmapped addresses and reserved bits read zero
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bus_rdata_q <= 8'h00;
        end
        else if (bus_rd && (bus_addr == `CC_ADDR_PIN_MODE))
        begin
            bus_rdata_q <= {main_ext_clock_sel_q, main_osc_pin_sel_q, sub_ext_clock_sel_q, sub_osc_pin_sel_q,
                1'b0, sub_drive_hi_q, sub_drive_lo_q, main_gain_sel_q};
        end
        else if (bus_rd && (bus_addr == `CC_ADDR_RUN_STOP))
        begin
            bus_rdata_q <= {main_osc_stop_q, sub_osc_stop_q, 5'h00, fast_rc_stop_q};
        end
        else if (bus_rd && (bus_addr == `CC_ADDR_CLK_SEL))
        begin
            bus_rdata_q <= {cpu_clock_status, cpu_clock_choice_q, main_clock_status, main_clock_choice_q,
                4'h0};
        end
        else if (bus_rd && (bus_addr == `CC_ADDR_PLL_CTRL))
        begin
            bus_rdata_q <= {pll_source_sel_q, 3'h0, pll_div_hi_q, pll_div_lo_q, pll_mult_sel_q,
                pll_run_sel_q};
        end
        else if (bus_rd)
        begin
            bus_rdata_q <= 8'h00;
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_pin_mode_once: assert property (pin_mode_written_q && wr_pin |=>
        $stable(main_osc_pin_sel_q) && $stable(main_ext_clock_sel_q) && $stable(sub_drive_lo_q))
        else $error("pin mode changed after its single write");
    a_sub_por_only: assert property (@(posedge clk) disable iff (!por_n)
        (!rst_n) |=> $stable(sub_drive_hi_q) && $stable(sub_osc_pin_sel_q))
        else $error("sub fields lost on non power-on reset");
    a_main_no_stop: assert property (main_clock_status && !cpu_clock_status |-> !main_osc_stop_q)
        else $error("fast system clock stopped while in use");
    a_sub_no_stop: assert property (cpu_clock_status |-> !sub_osc_stop_q)
        else $error("sub clock stopped while in use");
    a_rc_no_stop: assert property (!cpu_clock_status && !main_clock_status |-> !fast_rc_stop_q)
        else $error("fast RC stopped while in use");
    a_main_osc_run: assert property (main_mode == PIN_XTAL && !main_osc_stop_q |=> main_osc_en_q)
        else $error("main oscillator not enabled");
    a_pll_reserved: assert property (bus_rd && bus_addr == `CC_ADDR_PLL_CTRL |=> bus_rdata_q[6:4] == 3'h0)
        else $error("PLL reserved bits not zero");
    a_pll_div_four: assert property (pll_div_hi_q ##1 pll_div_hi_q |-> pll_div_shift_q == `CC_DIV_SHIFT_4)
        else $error("PLL divide-by-4 not applied");
    a_status_ignore: assert property (wr_sel && !fast_ok && !main_clock_status |=> !main_clock_status)
        else $error("main status set by software write");
    c_switch_fast: cover property (!main_clock_status ##1 main_clock_status);
    c_switch_sub: cover property (!cpu_clock_status ##1 cpu_clock_status);
    c_stop_refused: cover property (wr_run && bus_wdata[`CC_RS_RC_STOP] && !may_stop_rc);
endmodule : clk_source_ctrl

// File: logic/clk_switch_status.sv
`timescale 1ns/1ps
module clk_switch_status (
    input wire logic clk,         // System clock
    input wire logic rst_n,       // Sync reset, active low
    input wire logic cpu_choice,  // Requested CPU source
    input wire logic main_choice, // Requested main source
    input wire logic fast_ok,     // Fast system clock usable
    input wire logic rc_ok,       // Fast RC running
    input wire logic sub_ok,      // Sub clock usable
    output logic cpu_status_q,    // Sub clock in use
    output logic main_status_q    // Fast system clock in use
);
    // Main source follows its choice once the target runs
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            main_status_q <= 1'b0;
        end
        else if (main_choice && fast_ok)
        begin
            main_status_q <= 1'b1;
        end
        else if (!main_choice && rc_ok)
        begin
            main_status_q <= 1'b0;
        end
    end

    // CPU source follows its choice once the target runs; never back onto a stopped main source
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cpu_status_q <= 1'b0;
        end
        else if (cpu_choice && sub_ok)
        begin
            cpu_status_q <= 1'b1;
        end
        else if (!cpu_choice && (main_status_q ? fast_ok : rc_ok))
        begin
            cpu_status_q <= 1'b0;
        end
    end
endmodule : clk_switch_status

// File: logic/osc_stop_guard.sv
`timescale 1ns/1ps
module osc_stop_guard (
    input wire logic cpu_status,  // Sub clock in use
    input wire logic main_status, // Fast system clock in use
    output logic may_stop_main,   // Main oscillator free to stop
    output logic may_stop_sub,    // Sub oscillator free to stop
    output logic may_stop_rc      // Fast RC free to stop
);
    // Only a source not feeding the CPU clock may stop
    always_comb
    begin
        may_stop_main = (!cpu_status && !main_status) || cpu_status;
        may_stop_sub = !cpu_status;
        may_stop_rc = (!cpu_status && main_status) || cpu_status;
    end
endmodule : osc_stop_guard

// File: tb/system_clock_source_control_tb.sv
`timescale 1ns/1ps
`include "clk_ctrl_cfg.svh"
module system_clock_source_control_tb;
    import clk_ctrl_pkg::*;
    // ----------------------------------------------------------------
    // Signals and design
    // ----------------------------------------------------------------
    logic clk, rst_n, por_n, bus_wr, bus_rd, main_settled, sub_settled;
    logic [31:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata_q;
    pin_mode_t main_mode_q, sub_mode_q;
    logic main_osc_en_q, sub_osc_en_q, fast_rc_en_q, main_gain_q, cpu_on_sub_q, main_on_fast_q;
    logic pll_run_q, pll_src_fast_q, pll_mult16_q;
    logic [1:0] sub_drive_q, pll_div_shift_q;
    int bad_count, cmp_count;

    clk_source_ctrl uut (.clk(clk), .rst_n(rst_n), .por_n(por_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .main_settled(main_settled),
        .sub_settled(sub_settled), .bus_rdata_q(bus_rdata_q), .main_mode_q(main_mode_q),
        .sub_mode_q(sub_mode_q), .main_osc_en_q(main_osc_en_q), .sub_osc_en_q(sub_osc_en_q),
        .fast_rc_en_q(fast_rc_en_q), .sub_drive_q(sub_drive_q), .main_gain_q(main_gain_q),
        .cpu_on_sub_q(cpu_on_sub_q), .main_on_fast_q(main_on_fast_q), .pll_run_q(pll_run_q),
        .pll_src_fast_q(pll_src_fast_q), .pll_mult16_q(pll_mult16_q), .pll_div_shift_q(pll_div_shift_q));

    // Free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One write strobe, then an idle cycle so the strobe is never set twice at once
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge clk);
        bus_wr = 1'b0;
        @(negedge clk);
    endtask : wr

    // Read strobe; data is registered at the read edge and sampled at the next falling edge
    task automatic rd_chk(input string name, input logic [31:0] a, input logic [7:0] exp);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge clk);
        bus_rd = 1'b0;
        check(name, bus_rdata_q, exp);
        @(negedge clk);
    endtask : rd_chk

    // Bounded wait for the clock-in-use status pair
    task automatic wait_state(input logic sub_v, input logic fast_v);
        int n;
        n = 0;
        cmp_count++;
        while (!(cpu_on_sub_q === sub_v && main_on_fast_q === fast_v))
        begin
            @(negedge clk);
            n++;
            if (n > 20)
            begin
                bad_count++;
                $display("BAD clock_status expected %b%b seen %b%b", sub_v, fast_v, cpu_on_sub_q, main_on_fast_q);
                complete_run();
            end
        end
    endtask : wait_state

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd_chk("pin_mode", `CC_ADDR_PIN_MODE, 8'h00);
        rd_chk("run_stop", `CC_ADDR_RUN_STOP, 8'hC0);
        rd_chk("clk_sel", `CC_ADDR_CLK_SEL, 8'h00);
        rd_chk("pll_ctrl", `CC_ADDR_PLL_CTRL, 8'h00);
        rd_chk("unmapped", 32'h4002_0408, 8'h00);
        check("main_mode", {6'h00, main_mode_q}, {6'h00, PIN_PORT});
        check("fast_rc_en", {7'h00, fast_rc_en_q}, 8'h01);
        $display("test reset done");
    endtask : t_reset

    task automatic t_pin_once();
        wr(`CC_ADDR_PIN_MODE, 8'h53);
        wr(`CC_ADDR_PIN_MODE, 8'hFF);
        rd_chk("pin_mode", `CC_ADDR_PIN_MODE, 8'h53);
        check("main_mode", {6'h00, main_mode_q}, {6'h00, PIN_XTAL});
        check("sub_mode", {6'h00, sub_mode_q}, {6'h00, PIN_XTAL});
        check("drive_gain", {5'h00, sub_drive_q, main_gain_q}, 8'h03);
        wr(`CC_ADDR_RUN_STOP, 8'h00);
        check("osc_en", {6'h00, main_osc_en_q, sub_osc_en_q}, 8'h03);
        $display("test pin mode done");
    endtask : t_pin_once

    task automatic t_switch();
        main_settled = 1'b0;
        wr(`CC_ADDR_CLK_SEL, 8'h90);
        repeat (3) @(negedge clk);
        check("main_on_fast", {7'h00, main_on_fast_q}, 8'h00);
        main_settled = 1'b1;
        wait_state(1'b0, 1'b1);
        rd_chk("clk_sel", `CC_ADDR_CLK_SEL, 8'h30);
        wr(`CC_ADDR_RUN_STOP, 8'h81);
        rd_chk("run_stop", `CC_ADDR_RUN_STOP, 8'h01);
        check("fast_rc_en", {7'h00, fast_rc_en_q}, 8'h00);
        wr(`CC_ADDR_RUN_STOP, 8'h00);
        wr(`CC_ADDR_CLK_SEL, 8'h50);
        wait_state(1'b1, 1'b1);
        rd_chk("clk_sel", `CC_ADDR_CLK_SEL, 8'hF0);
        wr(`CC_ADDR_RUN_STOP, 8'h40);
        rd_chk("run_stop", `CC_ADDR_RUN_STOP, 8'h00);
        wr(`CC_ADDR_CLK_SEL, 8'h10);
        wait_state(1'b0, 1'b1);
        $display("test switch done");
    endtask : t_switch

    task automatic t_pll();
        logic [7:0] wv [3] = '{8'hFF, 8'h05, 8'h08};
        logic [7:0] rv [3] = '{8'h8F, 8'h05, 8'h08};
        logic [7:0] ov [3] = '{8'h1E, 8'h11, 8'h02};
        wr(`CC_ADDR_CLK_SEL, 8'h00);
        wait_state(1'b0, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            wr(`CC_ADDR_PLL_CTRL, wv[i]);
            rd_chk("pll_ctrl", `CC_ADDR_PLL_CTRL, rv[i]);
            check("pll_out", {3'h0, pll_run_q, pll_src_fast_q, pll_mult16_q, pll_div_shift_q}, ov[i]);
        end
        $display("test pll done");
    endtask : t_pll

    task automatic t_warm_reset();
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        rd_chk("pin_mode", `CC_ADDR_PIN_MODE, 8'h12);
        rd_chk("run_stop", `CC_ADDR_RUN_STOP, 8'hC0);
        wr(`CC_ADDR_PIN_MODE, 8'hD5);
        rd_chk("pin_mode", `CC_ADDR_PIN_MODE, 8'hD5);
        check("main_mode", {6'h00, main_mode_q}, {6'h00, PIN_EXT});
        check("drive", {6'h00, sub_drive_q}, 8'h02);
        por_n = 1'b0;
        repeat (2) @(negedge clk);
        por_n = 1'b1;
        rd_chk("pin_mode", `CC_ADDR_PIN_MODE, 8'h00);
        $display("test warm reset done");
    endtask : t_warm_reset

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        bad_count = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        por_n = 1'b0;
        bus_addr = 32'h0000_0000;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        main_settled = 1'b1;
        sub_settled = 1'b1;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        por_n = 1'b1;
        t_reset();
        t_pin_once();
        t_switch();
        t_pll();
        t_warm_reset();
        complete_run();
    end
endmodule : system_clock_source_control_tb
